/* hw/fti_ctrl.sv */
// Inspection mode controller for external bridge FETs and safety relays.
// Assumes synchronous inputs, a 25 MHz clock and a one-cycle read port.
// Operation
// - Inspection disables drain-source fault detection.
// - Low gate enable always forces pre-driver off.
// - Inspection block drives pre-drivers during automatic inspection.
// - Relay outputs always follow relay register.
// - Mid-voltage resistors on while inspection executes.
// - Unlock zero means normal operation only.
// - Manual bit enters manual inspection, inputs drive.
// - Manual mode feeds filter regardless of inputs.
// - Three bits select U, V, W resistors.
// - Start bit launches automatic sequence, flag high.
// - Type selects A, B, C or register pattern D.
// - Automatic sequence switches all resistors on.
// - Device compares A-C; host compares D.
// - Automatic beats manual when both requested.
// - Mismatch halts sequence; step number readable.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fti_ctrl
	import fti_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Gate control inputs, order uh ul vh vl wh wl
	input  wire logic [5:0]  fet_in,
	input  wire logic [5:0]  gate_en,
	input  wire logic [5:0]  vds_comp_filt,
	// Pre-driver, relay and resistor outputs
	output logic      [5:0]  predrv_on,
	output logic      [1:0]  relay_on,
	output logic      [2:0]  midres_on,
	output logic      [5:0]  filt_feed,
	output logic             vds_fault_en,
	output logic             irq
);
	// ****************************************************************
	// Expected values and helpers
	// ****************************************************************
	function automatic logic [5:0] expect_val(input logic [1:0] t, input logic [2:0] s);
		logic [5:0] v;
		v = 6'h3F;
		if (t == TYPE_A) begin
			if (s != 3'h0) v[6 - int'(s)] = 1'b0;
		end else if (s != 3'h0) begin
			v = (s < 3'h4) ? 6'h15 : 6'h2A;
		end
		return v;
	endfunction : expect_val

	function automatic logic [5:0] drive_pat(input logic [1:0] t, input logic [2:0] s);
		logic [5:0] v;
		v = 6'h00;
		if (s != 3'h0) begin
			if (t == TYPE_A) v[6 - int'(s)] = 1'b1;
			else v = (s < 3'h4) ? 6'h2A : 6'h15;
		end
		return v;
	endfunction : drive_pat

	function automatic logic [15:0] spread(input logic [5:0] v);
		return {5'h00, v[5], 1'b0, v[4], 1'b0, v[3], 1'b0, v[2], 1'b0, v[1], 1'b0, v[0]};
	endfunction : spread

	// ****************************************************************
	// State
	// ****************************************************************
	fti_pat_if pat ();
	fti_seq_type  st_q, st_d;
	logic [7:0]   ctrl_q, ctrl_d;
	logic         unlock_q, unlock_d;
	logic [1:0]   relay_q, relay_d;
	logic [1:0]   run_type_q, run_type_d;
	logic [2:0]   step_q, step_d;
	logic [15:0]  tmr_q, tmr_d;
	logic         err_q, err_d;
	logic [5:0]   saved_q, saved_d;
	logic [1:0]   ist_q, ist_d;
	logic [1:0]   imask_q, imask_d;
	logic [15:0]  rdata_q, rdata_d;
	logic [5:0]   pdrv_q, pdrv_d;
	logic [2:0]   mid_q, mid_d;
	logic [5:0]   feed_q, feed_d;
	logic         vds_en_q, vds_en_d;
	logic         irq_q, irq_d;
	logic         auto_act, manual_act, done_ev, err_ev;
	logic [5:0]   pattern;

	fti_pat_mem u_mem (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.port    (pat.mem)
	);

	assign auto_act   = (st_q != SEQ_IDLE);
	// A pending start request already locks manual mode out, so auto wins cleanly.
	assign manual_act = unlock_q && ctrl_q[CTRL_MANUAL_BIT]
		&& !ctrl_q[CTRL_START_BIT] && !auto_act;
	assign pat.wr_en   = reg_wr && (reg_addr >= ADDR_PATTERN_BASE) && (reg_addr < ADDR_RESULT);
	assign pat.wr_addr = 3'(reg_addr - ADDR_PATTERN_BASE);
	assign pat.wr_data = reg_wdata[5:0];
	assign pat.rd_addr = step_d;
	// The read address is step_d, so the one-cycle memory latency is hidden.
	assign pattern     = (run_type_q == TYPE_D) ? pat.rd_data : drive_pat(run_type_q, step_q);

	// ****************************************************************
	// Sequencer and registers
	// ****************************************************************
	// Next-state logic for the automatic sequence and the register file.
	always_comb begin
		// Default: every register holds and the read data fall back to zero.
		st_d       = st_q;
		ctrl_d     = ctrl_q;
		unlock_d   = unlock_q;
		relay_d    = relay_q;
		run_type_d = run_type_q;
		step_d     = step_q;
		tmr_d      = tmr_q;
		err_d      = err_q;
		saved_d    = saved_q;
		ist_d      = ist_q;
		imask_d    = imask_q;
		rdata_d    = 16'h0000;
		done_ev    = 1'b0;
		err_ev     = 1'b0;
		// The start bit is a one-cycle request, so it clears itself.
		ctrl_d[CTRL_START_BIT] = 1'b0;
		case (st_q)
			SEQ_IDLE: begin
				if (unlock_q && ctrl_q[CTRL_START_BIT]) begin
					// Latch the type so a later control write cannot swap patterns mid-run.
					st_d       = SEQ_SETTLE;
					run_type_d = ctrl_q[CTRL_TYPE_LSB +: 2];
					step_d     = 3'h0;
					tmr_d      = SETTLE_CYC;
					err_d      = 1'b0;
				end
			end
			SEQ_SETTLE: begin
				// The resistors pull the switch nodes to mid-voltage before any compare.
				tmr_d = tmr_q - 16'h0001;
				if (tmr_q == 16'h0001) begin
					st_d  = SEQ_STEP;
					tmr_d = STEP_CYC;
				end
			end
			SEQ_STEP: begin
				tmr_d = tmr_q - 16'h0001;
				if (tmr_q == 16'h0001) begin
					saved_d = vds_comp_filt;
					if (run_type_q != TYPE_D && vds_comp_filt != expect_val(run_type_q, step_q)) begin
						err_d   = 1'b1;
						err_ev  = 1'b1;
						st_d    = SEQ_IDLE;
						done_ev = 1'b1;
					end else if (int'(step_q) == NUM_STEPS - 1) begin
						st_d    = SEQ_IDLE;
						done_ev = 1'b1;
					end else begin
						step_d = step_q + 3'h1;
						tmr_d  = STEP_CYC;
					end
				end
			end
			default: st_d = SEQ_IDLE;
		endcase
		if (!unlock_q) st_d = SEQ_IDLE;
		if (reg_wr) begin
			case (reg_addr)
				ADDR_TEST_CTRL:   ctrl_d   = reg_wdata[7:0];
				ADDR_TEST_UNLOCK: unlock_d = reg_wdata[0];
				ADDR_RELAY_CTRL:  relay_d  = reg_wdata[1:0];
				ADDR_IRQ_MASK:    imask_d  = reg_wdata[1:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				ADDR_TEST_CTRL:   rdata_d = {8'h00, ctrl_q};
				ADDR_TEST_UNLOCK: rdata_d = {15'h0000, unlock_q};
				ADDR_COMP_STATUS: rdata_d = spread(ctrl_q[CTRL_COMPSEL_BIT] ? vds_comp_filt : saved_q);
				ADDR_RELAY_CTRL:  rdata_d = {14'h0000, relay_q};
				ADDR_RESULT:      rdata_d = {10'h000, auto_act, err_q, step_q, 1'b0};
				ADDR_IRQ_STATUS:  begin
					rdata_d = {14'h0000, ist_q};
					ist_d   = 2'h0;
				end
				ADDR_IRQ_MASK:    rdata_d = {14'h0000, imask_q};
				default:          rdata_d = RESET_WORD;
			endcase
		end
		// A new event wins over the read-to-clear.
		if (done_ev) ist_d[IRQ_DONE_BIT] = 1'b1;
		if (err_ev)  ist_d[IRQ_ERR_BIT]  = 1'b1;
	end

	// ****************************************************************
	// Output drive
	// ****************************************************************
	// Output selection: automatic inspection overrides normal drive, gate enable always wins.
	always_comb begin
		pdrv_d   = (auto_act ? pattern : fet_in) & gate_en;
		mid_d    = auto_act ? 3'h7 : (manual_act ? ctrl_q[CTRL_MIDRES_LSB +: 3] : 3'h0);
		feed_d   = (auto_act || manual_act) ? vds_comp_filt : (vds_comp_filt & fet_in);
		vds_en_d = !(auto_act || manual_act);
		irq_d    = |(ist_d & imask_d);
	end

	// Register everything.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			// Fault detection stays armed through reset; everything else is off.
			st_q       <= SEQ_IDLE;
			ctrl_q     <= 8'h00;
			unlock_q   <= 1'b0;
			relay_q    <= 2'h0;
			run_type_q <= TYPE_A;
			step_q     <= 3'h0;
			tmr_q      <= 16'h0000;
			err_q      <= 1'b0;
			saved_q    <= 6'h00;
			ist_q      <= 2'h0;
			imask_q    <= 2'h0;
			rdata_q    <= RESET_WORD;
			pdrv_q     <= 6'h00;
			mid_q      <= 3'h0;
			feed_q     <= 6'h00;
			vds_en_q   <= 1'b1;
			irq_q      <= 1'b0;
		end else begin
			st_q       <= st_d;
			ctrl_q     <= ctrl_d;
			unlock_q   <= unlock_d;
			relay_q    <= relay_d;
			run_type_q <= run_type_d;
			step_q     <= step_d;
			tmr_q      <= tmr_d;
			err_q      <= err_d;
			saved_q    <= saved_d;
			ist_q      <= ist_d;
			imask_q    <= imask_d;
			rdata_q    <= rdata_d;
			pdrv_q     <= pdrv_d;
			mid_q      <= mid_d;
			feed_q     <= feed_d;
			vds_en_q   <= vds_en_d;
			irq_q      <= irq_d;
		end
	end

	assign reg_rdata    = rdata_q;
	assign predrv_on    = pdrv_q;
	assign relay_on     = relay_q;
	assign midres_on    = mid_q;
	assign filt_feed    = feed_q;
	assign vds_fault_en = vds_en_q;
	assign irq          = irq_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	AST_VDS_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
		auto_act |=> !vds_fault_en) else $error("fault detection active during inspection");
	AST_GATE_EN: assert property (@(posedge ref_clk) disable iff (!resetn)
		(gate_en != 6'h3F) |=> ((predrv_on & ~$past(gate_en)) == 6'h00))
		else $error("pre-driver on with gate enable low");
	AST_AUTO_DRV: assert property (@(posedge ref_clk) disable iff (!resetn)
		(auto_act && run_type_q != TYPE_D) |=> predrv_on == ($past(pattern) & $past(gate_en)))
		else $error("pre-driver not from inspection pattern");
	AST_RELAY: assert property (@(posedge ref_clk) disable iff (!resetn)
		(reg_wr && reg_addr == ADDR_RELAY_CTRL) |=> relay_on == $past(reg_wdata[1:0]))
		else $error("relay output does not follow register");
	AST_MIDRES: assert property (@(posedge ref_clk) disable iff (!resetn)
		auto_act |=> midres_on == 3'h7) else $error("resistors not all on");
	AST_LOCKED: assert property (@(posedge ref_clk) disable iff (!resetn)
		!unlock_q |=> (!auto_act && midres_on == 3'h0)) else $error("inspection while locked");
	AST_MANUAL_FEED: assert property (@(posedge ref_clk) disable iff (!resetn)
		manual_act |=> filt_feed == $past(vds_comp_filt)) else $error("manual feed gated");
	AST_START: assert property (@(posedge ref_clk) disable iff (!resetn)
		(!auto_act && unlock_q && ctrl_q[CTRL_START_BIT] && unlock_d) |=> auto_act)
		else $error("sequence did not start");
	AST_HALT: assert property (@(posedge ref_clk) disable iff (!resetn)
		err_ev |=> (!auto_act && err_q && step_q == $past(step_q))) else $error("no halt on mismatch");
	// A joint request must never show the manual resistor choice, not even for one cycle.
	AST_PRIO: assert property (@(posedge ref_clk) disable iff (!resetn)
		(!auto_act && unlock_q && ctrl_q[CTRL_START_BIT] && ctrl_q[CTRL_MANUAL_BIT])
		|=> (midres_on == 3'h0) ##1 (midres_on == 3'h7)) else $error("manual mode beat auto start");
	// In manual mode each resistor follows its own control bit.
	AST_MANUAL_MID: assert property (@(posedge ref_clk) disable iff (!resetn)
		manual_act |=> midres_on == $past(ctrl_q[CTRL_MIDRES_LSB +: 3]))
		else $error("manual resistor select not applied");
	// Type D leaves the judgement to the host, so no error may be flagged.
	AST_D_NO_CMP: assert property (@(posedge ref_clk) disable iff (!resetn)
		(auto_act && run_type_q == TYPE_D) |=> !err_q) else $error("type D compared on chip");
	// An unmasked end of sequence must raise the interrupt on the next cycle.
	AST_IRQ_DONE: assert property (@(posedge ref_clk) disable iff (!resetn)
		(done_ev && imask_q[IRQ_DONE_BIT] && !reg_wr) |=> irq)
		else $error("sequence end raised no interrupt");
endmodule : fti_ctrl

/* hw/fti_pkg.sv */
// Package for the FET and relay inspection mode controller.
// Assumes a single 25 MHz clock and a plain address/strobe register port.
package fti_pkg;
	// ****************************************************************
	// Register map and field layout
	// ****************************************************************
	localparam logic [3:0] ADDR_TEST_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_TEST_UNLOCK  = 4'h1;
	localparam logic [3:0] ADDR_COMP_STATUS  = 4'h2;
	localparam logic [3:0] ADDR_RELAY_CTRL   = 4'h3;
	localparam logic [3:0] ADDR_PATTERN_BASE = 4'h4;
	localparam logic [3:0] ADDR_RESULT       = 4'hB;
	localparam logic [3:0] ADDR_IRQ_STATUS   = 4'hC;
	localparam logic [3:0] ADDR_IRQ_MASK     = 4'hD;
	localparam int         CTRL_MANUAL_BIT   = 0;
	localparam int         CTRL_START_BIT    = 1;
	localparam int         CTRL_TYPE_LSB     = 2;
	localparam int         CTRL_MIDRES_LSB   = 4;
	localparam int         CTRL_COMPSEL_BIT  = 7;
	localparam int         IRQ_DONE_BIT      = 0;
	localparam int         IRQ_ERR_BIT       = 1;
	localparam logic [15:0] RESET_WORD       = 16'h0000;
	// ****************************************************************
	// Sequence constants
	// ****************************************************************
	localparam int          NUM_STEPS       = 7;
	localparam int          CLK_NS          = 40;
	localparam int          SETTLE_NS       = 20000;
	localparam int          STEP_NS         = 4000;
	localparam logic [15:0] SETTLE_CYC      = 16'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] STEP_CYC        = 16'((STEP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [1:0]  TYPE_A          = 2'h0;
	localparam logic [1:0]  TYPE_B          = 2'h1;
	localparam logic [1:0]  TYPE_C          = 2'h2;
	localparam logic [1:0]  TYPE_D          = 2'h3;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETTLE, SEQ_STEP} fti_seq_type;
endpackage : fti_pkg

/* hw/fti_pat_if.sv */
// Interface carrying the Type D pattern memory port.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface fti_pat_if;
	logic       wr_en;
	logic [2:0] wr_addr;
	logic [5:0] wr_data;
	logic [2:0] rd_addr;
	logic [5:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : fti_pat_if

/* hw/fti_pat_mem.sv */
// Small memory holding the host-written Type D drive patterns.
// Assumes the controller drives the write and read address each cycle.
`timescale 1ns/1ps
module fti_pat_mem
	import fti_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Memory port
	fti_pat_if.mem   port
);
	logic [5:0] mem_q [NUM_STEPS];
	logic [5:0] mem_d [NUM_STEPS];
	logic [5:0] rd_q;
	logic [5:0] rd_d;

	// Write decode and registered read.
	always_comb begin
		mem_d = mem_q;
		if (port.wr_en && (int'(port.wr_addr) < NUM_STEPS)) begin
			mem_d[port.wr_addr] = port.wr_data;
		end
		rd_d = (int'(port.rd_addr) < NUM_STEPS) ? mem_q[port.rd_addr] : 6'h00;
	end

	// Storage registers.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_STEPS; i++) begin
				mem_q[i] <= 6'h00;
			end
			rd_q <= 6'h00;
		end else begin
			mem_q <= mem_d;
			rd_q  <= rd_d;
		end
	end
	assign port.rd_data = rd_q;
endmodule : fti_pat_mem

/* dv/fti_bridge_model.sv */
// Behavioural model of the external bridge FETs and their filtered comparators.
// Assumes the controller's pre-driver outputs drive it and the bench injects faults.
`timescale 1ns/1ps
module fti_bridge_model (
	// Drive from the controller
	input  wire logic [5:0] predrv_on,
	// Faults injected by the bench
	input  wire logic [5:0] stuck_hi,
	// Filtered comparator outputs
	output logic      [5:0] vds_comp_filt
);
	// A conducting FET shows a low drop, so its comparator reads low.
	// A FET stuck open never conducts, which is the fault the bench uses.
	assign vds_comp_filt = ~predrv_on | stuck_hi;
endmodule : fti_bridge_model

/* dv/fti_ctrl_tb_top.sv */
// Self-checking bench for the inspection mode controller.
// Assumes the bridge model on the comparator inputs and a 25 MHz clock.
`timescale 1ns/1ps
module fti_ctrl_tb_top
	import fti_pkg::*;
;
	logic        ref_clk, resetn, reg_wr, reg_rd, vds_fault_en, irq;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic [5:0]  fet_in, gate_en, vds_comp_filt, predrv_on, filt_feed, stuck_hi;
	logic [2:0]  midres_on;
	logic [1:0]  relay_on;
	int          err_count = 0;
	int          checks = 0;
	int          cyc = 0;
	fti_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.fet_in(fet_in), .gate_en(gate_en), .vds_comp_filt(vds_comp_filt),
		.predrv_on(predrv_on), .relay_on(relay_on), .midres_on(midres_on),
		.filt_feed(filt_feed), .vds_fault_en(vds_fault_en), .irq(irq));
	fti_bridge_model bridge (.predrv_on(predrv_on), .stuck_hi(stuck_hi),
		.vds_comp_filt(vds_comp_filt));
	// Comparator status places the six channels on the even bits.
	function automatic logic [15:0] spread(input logic [5:0] c);
		spread = {5'h00, c[5], 1'b0, c[4], 1'b0, c[3], 1'b0, c[2], 1'b0, c[1], 1'b0, c[0]};
	endfunction : spread
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so grab them there.
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic rchk(input string n, input logic [3:0] a, input logic [15:0] e);
		rd(a);
		chk(n, e, v);
	endtask : rchk
	task automatic pins(input logic [2:0] m, input logic f);
		#1;
		chk("midres_on", {13'h0000, m}, {13'h0000, midres_on});
		chk("vds_fault_en", {15'h0000, f}, {15'h0000, vds_fault_en});
	endtask : pins
	// Bounded wait, so a sequence that never ends shows up as a mismatch.
	task automatic wait_irq;
		int i;
		i = 0;
		while (irq !== 1'b1 && i < 2000) begin
			tick(1);
			i++;
		end
		chk("irq", 16'h0001, {15'h0000, irq});
	endtask : wait_irq
	task automatic run(input logic [15:0] ctl);
		wr(ADDR_TEST_CTRL, ctl);
		tick(3);
		pins(3'h7, 1'b0);
	endtask : run
	// Clock generator.
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Hang guard, well above the five sequences the tests launch.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			final_report;
		end
	end
	// Main test sequence.
	initial begin
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		fet_in = 6'h2A;
		gate_en = 6'h3D;
		stuck_hi = 6'h03;
		tick(3);
		pins(3'h0, 1'b1);
		chk("relay_on", 16'h0000, {14'h0000, relay_on});
		tick(1);
		resetn <= 1'b1;
		rchk("unlock", ADDR_TEST_UNLOCK, 16'h0000);
		wr(ADDR_IRQ_MASK, 16'h0003);
		wr(ADDR_RELAY_CTRL, 16'h0002);
		wr(ADDR_TEST_CTRL, 16'h00F1);
		tick(3);
		pins(3'h0, 1'b1);
		chk("relay_on", 16'h0002, {14'h0000, relay_on});
		chk("predrv_on", 16'h0028, {10'h000, predrv_on});
		chk("filt_feed", 16'h0002, {10'h000, filt_feed});
		$display("test normal done");
		wr(ADDR_TEST_UNLOCK, 16'h0001);
		for (int m = 1; m < 8; m++) begin
			wr(ADDR_TEST_CTRL, 16'h0081 | 16'(m << 4));
			tick(3);
			pins(3'(m), 1'b0);
			chk("predrv_on", 16'h0028, {10'h000, predrv_on});
			chk("filt_feed", 16'h0017, {10'h000, filt_feed});
			rchk("comp_status", ADDR_COMP_STATUS, spread(6'h17));
		end
		$display("test manual done");
		tick(1);
		stuck_hi <= 6'h20;
		run(16'h0002);
		rchk("result", ADDR_RESULT, 16'h0020);
		wait_irq;
		rchk("result", ADDR_RESULT, 16'h0012);
		rchk("saved comp", ADDR_COMP_STATUS, 16'h0555);
		rd(ADDR_IRQ_STATUS);
		chk("err irq", 16'h0002, v & 16'h0002);
		rchk("irq clear", ADDR_IRQ_STATUS, 16'h0000);
		$display("test type A fault done");
		tick(1);
		stuck_hi <= 6'h00;
		gate_en <= 6'h3F;
		run(16'h0002);
		wait_irq;
		// A clean run leaves the last step number behind with the error flag low.
		rchk("result", ADDR_RESULT, 16'h000C);
		rchk("done irq", ADDR_IRQ_STATUS, 16'h0001);
		$display("test type A pass done");
		for (int s = 0; s < 7; s++) begin
			wr(ADDR_PATTERN_BASE + 4'(s), (16'h0001 << s) & 16'h003F);
		end
		tick(1);
		stuck_hi <= 6'h01;
		gate_en <= 6'h3D;
		run(16'h001F);
		tick(545);
		chk("pattern 0", 16'h0001, {10'h000, predrv_on});
		tick(100);
		chk("pattern 1", 16'h0000, {10'h000, predrv_on});
		wait_irq;
		rchk("result", ADDR_RESULT, 16'h000C);
		rchk("saved comp", ADDR_COMP_STATUS, 16'h0555);
		rchk("done irq", ADDR_IRQ_STATUS, 16'h0001);
		$display("test type D done");
		for (int t = 1; t < 3; t++) begin
			run(16'h0002 | 16'(t << 2));
			wait_irq;
			rchk("result", ADDR_RESULT, 16'h0012);
			rchk("saved comp", ADDR_COMP_STATUS, spread(6'h17));
			rchk("err irq", ADDR_IRQ_STATUS, 16'h0003);
		end
		$display("test types B and C done");
		final_report;
	end
endmodule : fti_ctrl_tb_top
